// ===== design/comp_thresh_pkg.sv
package comp_thresh_pkg;
  // register indices, word-addressed on the plain port
  localparam logic [7:0] ADDR_AUX_OV      = 8'h3C;
  localparam logic [7:0] ADDR_ABS_AUX_UV  = 8'h3D;
  localparam logic [7:0] ADDR_CELL_OPEN   = 8'h3E;
  localparam logic [7:0] ADDR_RATIO_OPEN  = 8'h3F;
  localparam logic [7:0] ADDR_ABS_OPEN    = 8'h40;
  localparam logic [7:0] ADDR_MODE        = 8'hE0;
  localparam logic [7:0] ADDR_STATUS      = 8'hE1;
  localparam logic [7:0] ADDR_MASK        = 8'hE2;
  // field layout
  localparam int TH_LSB  = 4;
  localparam int TH_W    = 12;
  localparam int EV_W    = 3;
  localparam int EV_CELL_UV = 0;
  localparam int EV_AUX_UV  = 1;
  localparam int EV_AUX_OV  = 2;
  localparam int MODE_CELL_OPEN = 0;
  localparam int MODE_AUX_DIAG  = 1;
  // reset values
  localparam logic [11:0] TH_ZERO_RST = 12'h000;
  localparam logic [11:0] TH_ONES_RST = 12'hFFF;
endpackage

// ===== design/comp_thresh_regs.sv
`timescale 1ns/1ps
module comp_thresh_regs
  import comp_thresh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        scan_valid,
  input  wire logic        scan_is_aux,
  input  wire logic        aux_reference_select,
  input  wire logic [11:0] scan_result,
  output logic             irq
);
  import comp_thresh_pkg::*;

  logic [11:0]     ov_q, ov_d, auv_q, auv_d, copen_q, copen_d;
  logic [11:0]     ropen_q, ropen_d, aopen_q, aopen_d;
  logic [1:0]      mode_q, mode_d;
  logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [15:0]     rdata_q, rdata_d;
  logic [11:0]     uv_th;
  logic            uv_use;

  // threshold selection per input type and mode
  always_comb
  begin
    uv_use = 1'b0;
    uv_th  = TH_ZERO_RST;
    if (scan_is_aux)
    begin
      uv_use = 1'b1;
      if (mode_q[MODE_AUX_DIAG])
        uv_th = aux_reference_select ? aopen_q : ropen_q;
      else if (aux_reference_select)
        uv_th = auv_q;
      else
        uv_use = 1'b0;
    end
    else if (mode_q[MODE_CELL_OPEN])
    begin
      uv_use = 1'b1;
      uv_th  = copen_q;
    end
  end

  // events: strict less-than for undervoltage, greater-than for overvoltage, so a zero undervoltage threshold never fires
  always_comb
  begin
    ev = '0;
    if (scan_valid)
    begin
      ev[EV_AUX_UV]  = scan_is_aux & uv_use & (scan_result < uv_th);
      ev[EV_CELL_UV] = ~scan_is_aux & uv_use & (scan_result < uv_th);
      ev[EV_AUX_OV]  = scan_is_aux & aux_reference_select & ~mode_q[MODE_AUX_DIAG]
                       & (scan_result > ov_q);
    end
  end

  // register writes, write-one-clear status, read mux
  always_comb
  begin
    ov_d = ov_q; auv_d = auv_q; copen_d = copen_q;
    ropen_d = ropen_q; aopen_d = aopen_q; mode_d = mode_q; mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = 16'h0000;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_AUX_OV:     ov_d    = reg_wdata[TH_LSB +: TH_W];
        ADDR_ABS_AUX_UV: auv_d   = reg_wdata[TH_LSB +: TH_W];
        ADDR_CELL_OPEN:  copen_d = reg_wdata[TH_LSB +: TH_W];
        ADDR_RATIO_OPEN: ropen_d = reg_wdata[TH_LSB +: TH_W];
        ADDR_ABS_OPEN:   aopen_d = reg_wdata[TH_LSB +: TH_W];
        ADDR_MODE:       mode_d  = reg_wdata[1:0];
        ADDR_STATUS:     stat_d  = stat_q & ~reg_wdata[EV_W-1:0];
        ADDR_MASK:       mask_d  = reg_wdata[EV_W-1:0];
        default:         ;
      endcase
    end
    stat_d = stat_d | ev;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_AUX_OV:     rdata_d = {ov_q, 4'h0};
        ADDR_ABS_AUX_UV: rdata_d = {auv_q, 4'h0};
        ADDR_CELL_OPEN:  rdata_d = {copen_q, 4'h0};
        ADDR_RATIO_OPEN: rdata_d = {ropen_q, 4'h0};
        ADDR_ABS_OPEN:   rdata_d = {aopen_q, 4'h0};
        ADDR_MODE:       rdata_d = {14'h0000, mode_q};
        ADDR_STATUS:     rdata_d = {13'h0000, stat_q};
        ADDR_MASK:       rdata_d = {13'h0000, mask_q};
        default:         rdata_d = 16'h0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ov_q    <= TH_ONES_RST;
      auv_q   <= TH_ZERO_RST;
      copen_q <= TH_ZERO_RST;
      ropen_q <= TH_ZERO_RST;
      aopen_q <= TH_ZERO_RST;
      mode_q  <= 2'h0;
      stat_q  <= '0;
      mask_q  <= '0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ov_q    <= ov_d;
      auv_q   <= auv_d;
      copen_q <= copen_d;
      ropen_q <= ropen_d;
      aopen_q <= aopen_d;
      mode_q  <= mode_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(stat_q & mask_q);

  // one step of each scan kind, plus status read and aux undervoltage clear, shared by the properties below
  sequence s_abs_scan;
    scan_valid && scan_is_aux && aux_reference_select;
  endsequence

  sequence s_ratio_scan;
    scan_valid && scan_is_aux && !aux_reference_select;
  endsequence

  sequence s_cell_scan;
    scan_valid && !scan_is_aux;
  endsequence

  sequence s_read_status;
    reg_rd && reg_addr == ADDR_STATUS;
  endsequence

  sequence s_clear_aux_uv;
    reg_wr && reg_addr == ADDR_STATUS && reg_wdata[EV_AUX_UV];
  endsequence

  // alert selection and threshold checks
  chk_abs_uv_set: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_is_aux && aux_reference_select && !mode_q[MODE_AUX_DIAG]
    && scan_result < auv_q |=> stat_q[EV_AUX_UV])
    else $error("abs aux undervoltage alert missed");
  chk_zero_th_quiet: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_is_aux && !mode_q[MODE_AUX_DIAG] && auv_q == 12'h000
    |-> !ev[EV_AUX_UV])
    else $error("zero aux threshold raised alert");
  chk_cell_open_set: assert property (@(posedge clk) disable iff (rst)
    scan_valid && !scan_is_aux && mode_q[MODE_CELL_OPEN] && scan_result < copen_q
    |=> stat_q[EV_CELL_UV])
    else $error("cell open alert missed");
  chk_cell_zero_quiet: assert property (@(posedge clk) disable iff (rst)
    copen_q == 12'h000 |-> !ev[EV_CELL_UV])
    else $error("zero cell open threshold raised alert");
  chk_ratio_open: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_is_aux && !aux_reference_select && mode_q[MODE_AUX_DIAG]
    |-> ev[EV_AUX_UV] == (scan_result < ropen_q))
    else $error("ratiometric open compare wrong");
  chk_abs_open: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_is_aux && aux_reference_select && mode_q[MODE_AUX_DIAG]
    |-> ev[EV_AUX_UV] == (scan_result < aopen_q))
    else $error("absolute open compare wrong");
  chk_ov_ones_quiet: assert property (@(posedge clk) disable iff (rst)
    ov_q == 12'hFFF |-> !ev[EV_AUX_OV])
    else $error("all-ones overvoltage threshold raised alert");
  chk_equal_quiet: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_result == uv_th |-> !ev[EV_AUX_UV] && !ev[EV_CELL_UV])
    else $error("equal result raised undervoltage alert");
  chk_sticky: assert property (@(posedge clk) disable iff (rst)
    stat_q[EV_AUX_UV] && !(reg_wr && reg_addr == ADDR_STATUS) |=> stat_q[EV_AUX_UV])
    else $error("alert dropped without clear");
  chk_rd_thresh: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == ADDR_ABS_AUX_UV |=> reg_rdata == {$past(auv_q), 4'h0})
    else $error("threshold readback wrong");

  // overvoltage alert fires above the threshold, never at it
  chk_ov_set: assert property (@(posedge clk) disable iff (rst)
    s_abs_scan ##0 (!mode_q[MODE_AUX_DIAG] && scan_result > ov_q) |=> stat_q[EV_AUX_OV])
    else $error("overvoltage alert missed");

  chk_ov_equal_quiet: assert property (@(posedge clk) disable iff (rst)
    s_abs_scan ##0 (scan_result == ov_q) |-> !ev[EV_AUX_OV])
    else $error("equal result raised overvoltage alert");

  // ratiometric aux scans outside diag mode have no threshold here
  chk_ratio_normal_quiet: assert property (@(posedge clk) disable iff (rst)
    s_ratio_scan ##0 !mode_q[MODE_AUX_DIAG] |-> !ev[EV_AUX_UV])
    else $error("ratiometric scan alerted outside diag mode");

  // cell scans alert only in open-diag mode
  chk_cell_normal_quiet: assert property (@(posedge clk) disable iff (rst)
    s_cell_scan ##0 !mode_q[MODE_CELL_OPEN] |-> !ev[EV_CELL_UV])
    else $error("cell scan alerted outside open mode");

  chk_aux_no_cell: assert property (@(posedge clk) disable iff (rst)
    scan_valid && scan_is_aux |-> !ev[EV_CELL_UV])
    else $error("aux scan raised cell alert");

  chk_cell_no_aux: assert property (@(posedge clk) disable iff (rst)
    s_cell_scan |-> !ev[EV_AUX_UV] && !ev[EV_AUX_OV])
    else $error("cell scan raised aux alert");

  // zero open thresholds disable the open checks
  chk_ratio_zero_quiet: assert property (@(posedge clk) disable iff (rst)
    s_ratio_scan ##0 (mode_q[MODE_AUX_DIAG] && ropen_q == 12'h000) |-> !ev[EV_AUX_UV])
    else $error("zero ratiometric open threshold raised alert");

  chk_abs_open_zero: assert property (@(posedge clk) disable iff (rst)
    s_abs_scan ##0 (mode_q[MODE_AUX_DIAG] && aopen_q == 12'h000) |-> !ev[EV_AUX_UV])
    else $error("zero absolute open threshold raised alert");

  // writes land in the 12-bit field, one edge later
  chk_wr_abs_uv: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_ABS_AUX_UV |=> auv_q == $past(reg_wdata[TH_LSB +: TH_W]))
    else $error("absolute undervoltage write lost");

  chk_wr_cell_open: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_CELL_OPEN |=> copen_q == $past(reg_wdata[TH_LSB +: TH_W]))
    else $error("cell open threshold write lost");

  chk_wr_ratio_open: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_RATIO_OPEN |=> ropen_q == $past(reg_wdata[TH_LSB +: TH_W]))
    else $error("ratiometric open threshold write lost");

  chk_wr_abs_open: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_ABS_OPEN |=> aopen_q == $past(reg_wdata[TH_LSB +: TH_W]))
    else $error("absolute open threshold write lost");

  chk_wr_ov: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_AUX_OV |=> ov_q == $past(reg_wdata[TH_LSB +: TH_W]))
    else $error("overvoltage threshold write lost");

  // read data stands one cycle only, unused low bits read zero
  chk_rd_one_cycle: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data stood without a read");

  chk_rd_low_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rdata[3:0] == 4'h0 || $past(reg_addr) >= ADDR_MODE)
    else $error("threshold low bits read nonzero");

  chk_status_read: assert property (@(posedge clk) disable iff (rst)
    s_read_status |=> reg_rdata[EV_W-1:0] == $past(stat_q))
    else $error("status readback wrong");

  // write-one clear, with a same-cycle event winning
  chk_clear_aux_uv: assert property (@(posedge clk) disable iff (rst)
    s_clear_aux_uv ##0 !ev[EV_AUX_UV] |=> !stat_q[EV_AUX_UV])
    else $error("aux undervoltage alert not cleared");

  chk_set_wins: assert property (@(posedge clk) disable iff (rst)
    s_clear_aux_uv ##0 ev[EV_AUX_UV] |=> stat_q[EV_AUX_UV])
    else $error("clear beat a same-cycle alert");

  // no cell alert appears without its event, and the overvoltage alert holds until cleared
  chk_cell_no_spurious: assert property (@(posedge clk) disable iff (rst)
    !stat_q[EV_CELL_UV] && !ev[EV_CELL_UV] |=> !stat_q[EV_CELL_UV])
    else $error("cell alert set without event");

  chk_ov_sticky: assert property (@(posedge clk) disable iff (rst)
    stat_q[EV_AUX_OV] && !(reg_wr && reg_addr == ADDR_STATUS) |=> stat_q[EV_AUX_OV])
    else $error("overvoltage alert dropped without clear");
endmodule // comp_thresh_regs

// ===== test/comp_thresh_regs_tb.sv
`timescale 1ns/1ps
module comp_thresh_regs_tb;
  import comp_thresh_pkg::*;
  logic        clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        scan_valid;
  logic        scan_is_aux;
  logic        aux_reference_select;
  logic [11:0] scan_result;
  logic        irq;
  int          errors;
  int          n_tests;
  int          cycles;
  // device under test
  comp_thresh_regs u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_valid(scan_valid),
    .scan_is_aux(scan_is_aux), .aux_reference_select(aux_reference_select),
    .scan_result(scan_result), .irq(irq));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic complete_run();
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one-cycle write and read on the plain port
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  // one comparator result
  task automatic scn(input logic aux, input logic rsel, input logic [11:0] r);
    @(posedge clk);
    scan_valid <= 1'b1;
    scan_is_aux <= aux;
    aux_reference_select <= rsel;
    scan_result <= r;
    @(posedge clk);
    scan_valid <= 1'b0;
  endtask
  // status and irq, then clear every alert
  task automatic st(input logic [15:0] e);
    rd(ADDR_STATUS, e);
    chk("irq", {15'h0000, irq}, {15'h0000, |e});
    wr(ADDR_STATUS, 16'h0007);
  endtask
  task automatic t_reset();
    rd(ADDR_AUX_OV, 16'hFFF0);
    for (int i = 0; i < 4; i++)
      rd(8'(ADDR_ABS_AUX_UV + i), 16'h0000);
    rd(8'h55, 16'h0000);
    wr(ADDR_ABS_AUX_UV, 16'hABCF);
    rd(ADDR_ABS_AUX_UV, 16'hABC0);
  endtask
  task automatic t_abs_uv();
    wr(ADDR_ABS_AUX_UV, 16'h1000);
    scn(1'b1, 1'b1, 12'h100);
    st(16'h0000);
    scn(1'b1, 1'b1, 12'h0FF);
    scn(1'b1, 1'b1, 12'h100);
    st(16'h0002);
    wr(ADDR_ABS_AUX_UV, 16'h0000);
    scn(1'b1, 1'b1, 12'h000);
    st(16'h0000);
  endtask
  task automatic t_cell_open();
    wr(ADDR_MODE, 16'h0001);
    wr(ADDR_CELL_OPEN, 16'h8000);
    scn(1'b0, 1'b0, 12'h7FF);
    st(16'h0001);
    scn(1'b0, 1'b0, 12'h800);
    st(16'h0000);
    wr(ADDR_CELL_OPEN, 16'h0000);
    scn(1'b0, 1'b0, 12'h000);
    st(16'h0000);
  endtask
  task automatic t_aux_open();
    wr(ADDR_MODE, 16'h0002);
    wr(ADDR_RATIO_OPEN, 16'h4000);
    wr(ADDR_ABS_OPEN, 16'h2000);
    scn(1'b1, 1'b0, 12'h3FF);
    st(16'h0002);
    scn(1'b1, 1'b1, 12'h3FF);
    st(16'h0000);
    scn(1'b1, 1'b1, 12'h1FF);
    st(16'h0002);
    wr(ADDR_RATIO_OPEN, 16'h0000);
    scn(1'b1, 1'b0, 12'h000);
    st(16'h0000);
  endtask
  task automatic t_ov();
    wr(ADDR_MODE, 16'h0000);
    scn(1'b1, 1'b1, 12'hFFF);
    st(16'h0000);
    wr(ADDR_AUX_OV, 16'hF000);
    scn(1'b1, 1'b1, 12'hF01);
    st(16'h0004);
    wr(ADDR_MASK, 16'h0000);
    scn(1'b1, 1'b1, 12'hF01);
    rd(ADDR_STATUS, 16'h0004);
    chk("irq", {15'h0000, irq}, 16'h0000);
  endtask
  // main sequence
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {scan_valid, scan_is_aux, aux_reference_select, scan_result} = '0;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    wr(ADDR_MASK, 16'h0007);
    t_abs_uv();
    t_cell_open();
    t_aux_open();
    t_ov();
    complete_run();
  end
endmodule // comp_thresh_regs_tb
